// ### rtl/alsm_pkg.sv
package alsm_pkg;
  // ----------------------------------------
  // Command codes and payload lengths
  // ----------------------------------------
  localparam logic [7:0] CODE_AOI_LEN = 8'hAB;
  localparam logic [7:0] CODE_SHADE = 8'hC5;
  localparam logic [7:0] LEN_AOI = 8'h02;
  localparam logic [7:0] LEN_SHADE = 8'h01;
  // ----------------------------------------
  // Shading output modes
  // ----------------------------------------
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_TEST = 8'h01;
  localparam logic [7:0] MODE_ON = 8'h02;
  // ----------------------------------------
  // Length limits and reset values
  // ----------------------------------------
  localparam logic [15:0] AOI_MIN = 16'h0001;
  localparam logic [15:0] AOI_MAX_1K = 16'h0400;
  localparam logic [15:0] AOI_MAX_2K = 16'h0800;
  localparam logic [15:0] AOI_RST = AOI_MAX_2K;
  localparam logic [7:0] MODE_RST = MODE_OFF;
  // ----------------------------------------
  // Interpreter states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_REPLY = 3'b100
  } alsm_state_t;
endpackage

// ### rtl/alsm_store.sv
module alsm_store #(
  parameter logic [15:0] MAX_LEN = alsm_pkg::AOI_MAX_2K
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Write strobes
  input wire logic wr_len_stb,
  input wire logic [15:0] wr_len,
  input wire logic wr_mode_stb,
  input wire logic [7:0] wr_mode,
  // Settings
  output logic [15:0] aoi_len_r,
  output logic [7:0] mode_r,
  output logic shade_on_r,
  output logic shade_test_r
);
  logic len_ok;
  logic mode_ok;

  // Host must keep the length in range; out of range writes are dropped
  assign len_ok = (wr_len >= alsm_pkg::AOI_MIN) && (wr_len <= MAX_LEN);
  assign mode_ok = (wr_mode == alsm_pkg::MODE_OFF) || (wr_mode == alsm_pkg::MODE_TEST) ||
                   (wr_mode == alsm_pkg::MODE_ON);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aoi_len_r <= alsm_pkg::AOI_RST;
    end else if (wr_len_stb && len_ok) begin
      aoi_len_r <= wr_len;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= alsm_pkg::MODE_RST;
      shade_on_r <= 1'b0;
      shade_test_r <= 1'b0;
    end else if (wr_mode_stb && mode_ok) begin
      mode_r <= wr_mode;
      shade_on_r <= (wr_mode == alsm_pkg::MODE_ON);
      shade_test_r <= (wr_mode == alsm_pkg::MODE_TEST);
    end
  end

  chk_shade_on_decode: assert property (@(posedge mclk) disable iff (rst)
    shade_on_r == (mode_r == alsm_pkg::MODE_ON))
    else $error("shade_on does not match mode");
  chk_test_image_decode: assert property (@(posedge mclk) disable iff (rst)
    shade_test_r == (mode_r == alsm_pkg::MODE_TEST))
    else $error("test image flag does not match mode");
  chk_bad_len_kept: assert property (@(posedge mclk) disable iff (rst)
    wr_len_stb && !len_ok |=> $stable(aoi_len_r))
    else $error("out of range length changed setting");
  chk_bad_mode_kept: assert property (@(posedge mclk) disable iff (rst)
    wr_mode_stb && !mode_ok |=> $stable(mode_r))
    else $error("undefined mode changed setting");
endmodule // alsm_store

// ### rtl/alsm_cmd.sv
module alsm_cmd #(
  parameter logic [15:0] MAX_LEN = alsm_pkg::AOI_MAX_2K
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Received frame header
  input wire logic hdr_valid,
  input wire logic [7:0] hdr_code,
  input wire logic hdr_rd,
  input wire logic [7:0] hdr_len,
  // Received payload bytes
  input wire logic dat_valid,
  input wire logic [7:0] dat_byte,
  // Response frame
  output logic rsp_hdr_valid,
  output logic [7:0] rsp_code,
  output logic rsp_rd,
  output logic [7:0] rsp_len,
  output logic rsp_dat_valid,
  output logic [7:0] rsp_dat_byte,
  output logic rsp_last,
  // Settings for the video path
  output logic [15:0] aoi_length,
  output logic [7:0] shade_mode,
  output logic shade_on,
  output logic shade_test
);
  // ----------------------------------------
  // Decode and state
  // ----------------------------------------
  alsm_pkg::alsm_state_t state_r;
  logic sel_aoi_r;
  logic cnt_r;
  logic [7:0] lo_r;
  logic wr_len_stb_r;
  logic wr_mode_stb_r;
  logic [15:0] wr_len_r;
  logic [7:0] wr_mode_r;
  logic hit_aoi;
  logic hit_shade;
  logic [15:0] wr_val;

  assign hit_aoi = (hdr_code == alsm_pkg::CODE_AOI_LEN) && (hdr_len == alsm_pkg::LEN_AOI);
  assign hit_shade = (hdr_code == alsm_pkg::CODE_SHADE) && (hdr_len == alsm_pkg::LEN_SHADE);
  assign wr_val = {dat_byte, lo_r};

  // Frames for other codes are left to their own handlers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= alsm_pkg::ST_IDLE;
      sel_aoi_r <= 1'b0;
      cnt_r <= 1'b0;
      lo_r <= 8'h00;
    end else begin
      case (state_r)
        alsm_pkg::ST_IDLE: begin
          if (hdr_valid && (hit_aoi || hit_shade)) begin
            sel_aoi_r <= hit_aoi;
            cnt_r <= 1'b0;
            state_r <= hdr_rd ? alsm_pkg::ST_REPLY : alsm_pkg::ST_DATA;
          end
        end
        alsm_pkg::ST_DATA: begin
          // A new header abandons an unfinished write
          if (hdr_valid) begin
            state_r <= alsm_pkg::ST_IDLE;
          end else if (dat_valid) begin
            if (sel_aoi_r && !cnt_r) begin
              lo_r <= dat_byte;
              cnt_r <= 1'b1;
            end else begin
              state_r <= alsm_pkg::ST_IDLE;
            end
          end
        end
        alsm_pkg::ST_REPLY: begin
          cnt_r <= 1'b1;
          if (cnt_r || !sel_aoi_r) begin
            state_r <= alsm_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= alsm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_len_stb_r <= 1'b0;
      wr_mode_stb_r <= 1'b0;
      wr_len_r <= 16'h0000;
      wr_mode_r <= 8'h00;
    end else begin
      wr_len_stb_r <= 1'b0;
      wr_mode_stb_r <= 1'b0;
      if (state_r == alsm_pkg::ST_DATA && !hdr_valid && dat_valid) begin
        if (sel_aoi_r && cnt_r) begin
          wr_len_stb_r <= 1'b1;
          wr_len_r <= wr_val;
        end else if (!sel_aoi_r) begin
          wr_mode_stb_r <= 1'b1;
          wr_mode_r <= dat_byte;
        end
      end
    end
  end

  // ----------------------------------------
  // Response
  // ----------------------------------------
  // Reply bytes read the live setting; no write can land during a reply
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_hdr_valid <= 1'b0;
      rsp_code <= 8'h00;
      rsp_rd <= 1'b0;
      rsp_len <= 8'h00;
      rsp_dat_valid <= 1'b0;
      rsp_dat_byte <= 8'h00;
      rsp_last <= 1'b0;
    end else begin
      rsp_hdr_valid <= 1'b0;
      rsp_dat_valid <= 1'b0;
      rsp_last <= 1'b0;
      if (state_r == alsm_pkg::ST_IDLE && hdr_valid && hdr_rd && (hit_aoi || hit_shade)) begin
        rsp_hdr_valid <= 1'b1;
        rsp_code <= hdr_code;
        rsp_rd <= 1'b0;
        rsp_len <= hdr_len;
      end
      if (state_r == alsm_pkg::ST_REPLY) begin
        rsp_dat_valid <= 1'b1;
        if (!sel_aoi_r) begin
          rsp_dat_byte <= shade_mode;
          rsp_last <= 1'b1;
        end else if (!cnt_r) begin
          rsp_dat_byte <= aoi_length[7:0];
        end else begin
          rsp_dat_byte <= aoi_length[15:8];
          rsp_last <= 1'b1;
        end
      end
    end
  end

  alsm_store #(
    .MAX_LEN(MAX_LEN)
  ) u_store (
    .mclk(mclk),
    .rst(rst),
    .wr_len_stb(wr_len_stb_r),
    .wr_len(wr_len_r),
    .wr_mode_stb(wr_mode_stb_r),
    .wr_mode(wr_mode_r),
    .aoi_len_r(aoi_length),
    .mode_r(shade_mode),
    .shade_on_r(shade_on),
    .shade_test_r(shade_test)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_len_read_reply: assert property (
    state_r == alsm_pkg::ST_IDLE && hdr_valid && hdr_rd && hit_aoi |=>
    rsp_hdr_valid && rsp_code == alsm_pkg::CODE_AOI_LEN && !rsp_rd && rsp_len == alsm_pkg::LEN_AOI)
    else $error("length read not answered correctly");
  chk_write_no_reply: assert property (
    state_r == alsm_pkg::ST_IDLE && hdr_valid && !hdr_rd && (hit_aoi || hit_shade) |=>
    !rsp_hdr_valid ##1 !rsp_dat_valid)
    else $error("write produced a response");
  chk_len_update: assert property (
    state_r == alsm_pkg::ST_DATA && !hdr_valid && dat_valid && sel_aoi_r && cnt_r &&
    wr_val >= alsm_pkg::AOI_MIN && wr_val <= MAX_LEN |-> ##2 aoi_length == $past(wr_val, 2))
    else $error("length write not stored");
  chk_len_byte_order: assert property (
    rsp_hdr_valid && rsp_code == alsm_pkg::CODE_AOI_LEN |=>
    rsp_dat_valid && !rsp_last && rsp_dat_byte == aoi_length[7:0] ##1
    rsp_dat_valid && rsp_last && rsp_dat_byte == aoi_length[15:8])
    else $error("length reply byte order wrong");
  chk_mode_reply: assert property (
    state_r == alsm_pkg::ST_IDLE && hdr_valid && hdr_rd && hit_shade |=>
    rsp_hdr_valid && rsp_len == alsm_pkg::LEN_SHADE && rsp_code == alsm_pkg::CODE_SHADE ##1
    rsp_dat_valid && rsp_last && rsp_dat_byte == shade_mode)
    else $error("mode read not answered correctly");

  cov_len_read: cover property (rsp_hdr_valid && rsp_code == alsm_pkg::CODE_AOI_LEN ##2 rsp_last);
  cov_len_write: cover property (wr_len_stb_r ##1 $changed(aoi_length));
  cov_test_image: cover property ($rose(shade_test));
  cov_bad_len: cover property (wr_len_stb_r && wr_len_r > MAX_LEN);
endmodule // alsm_cmd

// ### test/alsm_host.sv
module alsm_host (
  // Clock
  input wire logic mclk,
  // Frame header
  output logic hdr_valid,
  output logic [7:0] hdr_code,
  output logic hdr_rd,
  output logic [7:0] hdr_len,
  // Payload
  output logic dat_valid,
  output logic [7:0] dat_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    hdr_valid = 1'b0;
    hdr_code = 8'h00;
    hdr_rd = 1'b0;
    hdr_len = 8'h00;
    dat_valid = 1'b0;
    dat_byte = 8'h00;
  end
  // One header pulse; fields scrambled after so stale values never match
  task automatic send_hdr(input logic [7:0] code, input logic rd, input logic [7:0] len);
    @(posedge mclk);
    #1;
    hdr_valid = 1'b1;
    hdr_code = code;
    hdr_rd = rd;
    hdr_len = len;
    @(posedge mclk);
    #1;
    hdr_valid = 1'b0;
    hdr_code = ~code;
    hdr_rd = ~rd;
    hdr_len = ~len;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(posedge mclk);
    #1;
    dat_valid = 1'b1;
    dat_byte = b;
    @(posedge mclk);
    #1;
    dat_valid = 1'b0;
    dat_byte = ~b;
  endtask
endmodule // alsm_host

// ### test/test_aoi_length_shading_mode_cmds.sv
module test_aoi_length_shading_mode_cmds;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, hdr_valid, hdr_rd, dat_valid, rsp_hdr_valid, rsp_rd, rsp_dat_valid, rsp_last;
  logic shade_on, shade_test;
  logic [7:0] hdr_code, hdr_len, dat_byte, rsp_code, rsp_len, rsp_dat_byte, shade_mode;
  logic [15:0] aoi_length, len_2k;
  int bad_count, num_checks;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  alsm_host host (.mclk(mclk), .hdr_valid(hdr_valid), .hdr_code(hdr_code), .hdr_rd(hdr_rd),
    .hdr_len(hdr_len), .dat_valid(dat_valid), .dat_byte(dat_byte));
  // 1K sensor so the upper range bound sits below that of the 2K copy
  alsm_cmd #(.MAX_LEN(16'h0400)) uut (.mclk(mclk), .rst(rst), .hdr_valid(hdr_valid),
    .hdr_code(hdr_code), .hdr_rd(hdr_rd), .hdr_len(hdr_len), .dat_valid(dat_valid),
    .dat_byte(dat_byte), .rsp_hdr_valid(rsp_hdr_valid), .rsp_code(rsp_code), .rsp_rd(rsp_rd),
    .rsp_len(rsp_len), .rsp_dat_valid(rsp_dat_valid), .rsp_dat_byte(rsp_dat_byte),
    .rsp_last(rsp_last), .aoi_length(aoi_length), .shade_mode(shade_mode), .shade_on(shade_on),
    .shade_test(shade_test));
  // Second copy on a 2K sensor shares the host's stimulus; only its length is watched
  alsm_cmd uut_2k (.mclk(mclk), .rst(rst), .hdr_valid(hdr_valid), .hdr_code(hdr_code), .hdr_rd(hdr_rd),
    .hdr_len(hdr_len), .dat_valid(dat_valid), .dat_byte(dat_byte), .rsp_hdr_valid(), .rsp_code(), .rsp_rd(),
    .rsp_len(), .rsp_dat_valid(), .rsp_dat_byte(), .rsp_last(), .aoi_length(len_2k), .shade_mode(),
    .shade_on(), .shade_test());
  // Wide enough for the response header with both flag bits
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic wr_len(input logic [15:0] v);
    host.send_hdr(8'hAB, 1'b0, 8'h02);
    host.send_byte(v[7:0]);
    host.send_byte(v[15:8]);
    step();
    step();
  endtask
  task automatic rd_len(input logic [15:0] exp);
    host.send_hdr(8'hAB, 1'b1, 8'h02);
    chk({rsp_hdr_valid, rsp_rd, rsp_code, rsp_len}, {2'b10, 8'hAB, 8'h02});
    step();
    chk({rsp_dat_valid, rsp_last, rsp_dat_byte}, {2'b10, exp[7:0]});
    step();
    chk({rsp_dat_valid, rsp_last, rsp_dat_byte}, {2'b11, exp[15:8]});
  endtask
  task automatic t_reset;
    chk(aoi_length, 16'h0800);
    chk({shade_on, shade_test, shade_mode}, 10'h000);
    $display("test reset done");
  endtask
  task automatic t_len;
    wr_len(16'h0400);
    chk(aoi_length, 16'h0400);
    rd_len(16'h0400);
    wr_len(16'h0123);
    chk(rsp_hdr_valid, 1'b0);
    rd_len(16'h0123);
    wr_len(16'h0001);
    rd_len(16'h0001);
    $display("test length done");
  endtask
  task automatic t_bad;
    wr_len(16'h0401);
    chk(aoi_length, 16'h0001);
    wr_len(16'h0000);
    chk(aoi_length, 16'h0001);
    rd_len(16'h0001);
    wr_len(16'h0800);
    chk(aoi_length, 16'h0001);
    chk(len_2k, 16'h0800);
    wr_len(16'h0801);
    chk(len_2k, 16'h0800);
    $display("test refused length done");
  endtask
  // Mode 3 is undefined and must leave mode 2 in place
  task automatic t_mode;
    logic [7:0] exp;
    for (int m = 0; m < 4; m++) begin
      exp = (m < 3) ? 8'(m) : 8'h02;
      host.send_hdr(8'hC5, 1'b0, 8'h01);
      host.send_byte(8'(m));
      step();
      step();
      chk(shade_mode, exp);
      chk({shade_on, shade_test}, {exp == 8'h02, exp == 8'h01});
      host.send_hdr(8'hC5, 1'b1, 8'h01);
      chk({rsp_hdr_valid, rsp_rd, rsp_code, rsp_len}, {2'b10, 8'hC5, 8'h01});
      step();
      chk({rsp_dat_valid, rsp_last, rsp_dat_byte}, {2'b11, exp});
    end
    $display("test mode done");
  endtask
  initial begin
    rst = 1'b1;
    bad_count = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_len();
    t_bad();
    t_mode();
    results();
  end
  // Whole run is about 110 cycles; this is ample margin
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule // test_aoi_length_shading_mode_cmds
